// ---- hw/acr_regs.svh ----
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// Register addresses
`define ACR_ADDR_CH2_CONFIG      8'h13
`define ACR_ADDR_CH2_OFFSET_HIGH 8'h14
`define ACR_ADDR_CH2_OFFSET_LOW  8'h15
`define ACR_ADDR_CH2_GAIN_HIGH   8'h16
`define ACR_ADDR_CH2_GAIN_LOW    8'h17
`define ACR_ADDR_CH3_CONFIG      8'h18
`define ACR_ADDR_CH3_OFFSET_HIGH 8'h19

// Reset values
`define ACR_RST_CH2_CONFIG       16'h0000
`define ACR_RST_CH2_OFFSET_HIGH  16'h0000
`define ACR_RST_CH2_OFFSET_LOW   16'h0000
`define ACR_RST_CH2_GAIN_HIGH    16'h8000
`define ACR_RST_CH2_GAIN_LOW     16'h0000
`define ACR_RST_CH3_CONFIG       16'h0000
`define ACR_RST_CH3_OFFSET_HIGH  16'h0000

// Field positions
`define ACR_SEL_MSB              1
`define ACR_SEL_LSB              0
`define ACR_CFG_RO_MSB           5
`define ACR_CFG_RO_LSB           3
`define ACR_LOW_FIELD_MSB        15
`define ACR_LOW_FIELD_LSB        8
`define ACR_LOW_RSVD_MSB         7
`define ACR_LOW_RSVD_LSB         0

// Writable bit masks; read-only reserved bits stay zero
`define ACR_CFG_WMASK            16'hffc7
`define ACR_LOW_WMASK            16'hff00

`endif

// ---- hw/acr_pkg.sv ----
package acr_pkg;

    typedef enum logic [1:0] {
        ACR_SEL_PINS     = 2'b00,
        ACR_SEL_SHORTED  = 2'b01,
        ACR_SEL_TEST_POS = 2'b10,
        ACR_SEL_TEST_NEG = 2'b11
    } acr_input_sel_t;

    typedef logic [15:0] acr_word_t;
    typedef logic [23:0] acr_cal_t;

endpackage

// ---- hw/acr_input_route.sv ----
`timescale 1ns/1ps

module acr_input_route (
    input logic [1:0] sel, // Input-select field
    output logic pins_on, // Own positive and negative pins routed
    output logic shorted, // Pins off, converter inputs shorted
    output logic test_pos, // Positive dc test signal applied
    output logic test_neg // Negative dc test signal applied
);

    always_comb begin
        pins_on = 1'b0;
        shorted = 1'b0;
        test_pos = 1'b0;
        test_neg = 1'b0;
        unique case (acr_pkg::acr_input_sel_t'(sel))
            acr_pkg::ACR_SEL_PINS: begin
                pins_on = 1'b1;
            end
            acr_pkg::ACR_SEL_SHORTED: begin
                shorted = 1'b1;
            end
            acr_pkg::ACR_SEL_TEST_POS: begin
                test_pos = 1'b1;
            end
            acr_pkg::ACR_SEL_TEST_NEG: begin
                test_neg = 1'b1;
            end
        endcase
    end

endmodule

// ---- hw/acr_cal_join.sv ----
`timescale 1ns/1ps

module acr_cal_join #(
    parameter bit IS_SIGNED = 1'b1
) (
    input logic [15:0] upper_bits, // Value bits 23..8
    input logic [15:0] lower_reg, // Low register, value bits 7..0 on top
    output logic [23:0] value, // Joined 24-bit value
    output logic top_flag // Signed: negative; unsigned: gain >= 1.0
);

    assign value = {upper_bits, lower_reg[15:8]};

    // Two's-complement sign, or the 1.0 weight of an unsigned 1.23 gain
    assign top_flag = IS_SIGNED ? ($signed(value) < 24'sh000000) : value[23];

endmodule

// ---- hw/acr_calib_regs.sv ----
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "acr_regs.svh"

// Function
// - Channel 2 select: 00 pins, 01 shorted, 10 test plus, 11 test minus.
// - Channel 3 select uses the same four-way encoding as channel 2.
// - Channel 2 offset bits 23..8 sit in the whole offset-high register.
// - Channel 2 offset bits 7..0 in offset-low 15..8; low byte reserved.
// - Joined 24-bit offset is a signed two's-complement number.
// - Gain bits 23..8 sit in the whole 16-bit gain-high register.
// - Gain bits 7..0 in gain-low 15..8; low byte reserved.
// - Gain is unsigned, 0.0 up to just below 2.0, steps of 2^-23.
// - Channel 2 gain-high at 16h resets to 8000h, unity gain.
// - Channel 2 offset-high at 14h resets to 0000h, zero offset.
// - Channel 3 config at 18h holds its select, resets to 0000h.
// - Channel 3 offset-high at 19h holds bits 23..8, resets 0000h.

module acr_calib_regs (
    input logic core_clk, // 125 MHz clock
    input logic nrst, // Synchronous reset, active low
    input logic [7:0] reg_addr, // Register address
    input logic [15:0] reg_wdata, // Write data
    input logic reg_wr, // Write strobe
    input logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after the strobe
    output logic [1:0] ch2_input_select, // Channel 2 select field
    output logic ch2_pins_on, // Channel 2 own pins routed
    output logic ch2_shorted, // Channel 2 inputs shorted
    output logic ch2_test_pos, // Channel 2 positive test signal
    output logic ch2_test_neg, // Channel 2 negative test signal
    output logic [1:0] ch3_input_select, // Channel 3 select field
    output logic ch3_pins_on, // Channel 3 own pins routed
    output logic ch3_shorted, // Channel 3 inputs shorted
    output logic ch3_test_pos, // Channel 3 positive test signal
    output logic ch3_test_neg, // Channel 3 negative test signal
    output logic [23:0] ch2_offset, // Channel 2 offset, two's complement
    output logic ch2_offset_neg, // Channel 2 offset below zero
    output logic [23:0] ch2_gain, // Channel 2 gain, unsigned 1.23
    output logic ch2_gain_ge_one, // Channel 2 gain at or above 1.0
    output logic [15:0] ch3_offset_upper_bits // Channel 3 offset 23..8
);

    acr_pkg::acr_word_t ch2_config_reg, ch2_config_next;
    acr_pkg::acr_word_t ch2_offset_high_reg, ch2_offset_high_next;
    acr_pkg::acr_word_t ch2_offset_low_reg, ch2_offset_low_next;
    acr_pkg::acr_word_t ch2_gain_high_reg, ch2_gain_high_next;
    acr_pkg::acr_word_t ch2_gain_low_reg, ch2_gain_low_next;
    acr_pkg::acr_word_t ch3_config_reg, ch3_config_next;
    acr_pkg::acr_word_t ch3_offset_high_reg, ch3_offset_high_next;
    acr_pkg::acr_word_t rdata_reg, rdata_next;

    logic [1:0] sel_arr [2];
    logic [3:0] route_arr [2];

    // Read-only reserved config bits are forced to zero on write
    function automatic acr_pkg::acr_word_t cfg_write(
        input acr_pkg::acr_word_t data
    );
        cfg_write = data & `ACR_CFG_WMASK;
    endfunction

    // Low byte of calibration low registers is read-only zero
    function automatic acr_pkg::acr_word_t low_write(
        input acr_pkg::acr_word_t data
    );
        low_write = data & `ACR_LOW_WMASK;
    endfunction

    always_comb begin
        ch2_config_next = ch2_config_reg;
        ch2_offset_high_next = ch2_offset_high_reg;
        ch2_offset_low_next = ch2_offset_low_reg;
        ch2_gain_high_next = ch2_gain_high_reg;
        ch2_gain_low_next = ch2_gain_low_reg;
        ch3_config_next = ch3_config_reg;
        ch3_offset_high_next = ch3_offset_high_reg;
        rdata_next = 16'h0000;
        if (reg_wr) begin
            case (reg_addr)
                `ACR_ADDR_CH2_CONFIG: begin
                    ch2_config_next = cfg_write(reg_wdata);
                end
                `ACR_ADDR_CH2_OFFSET_HIGH: begin
                    ch2_offset_high_next = reg_wdata;
                end
                `ACR_ADDR_CH2_OFFSET_LOW: begin
                    ch2_offset_low_next = low_write(reg_wdata);
                end
                `ACR_ADDR_CH2_GAIN_HIGH: begin
                    ch2_gain_high_next = reg_wdata;
                end
                `ACR_ADDR_CH2_GAIN_LOW: begin
                    ch2_gain_low_next = low_write(reg_wdata);
                end
                `ACR_ADDR_CH3_CONFIG: begin
                    ch3_config_next = cfg_write(reg_wdata);
                end
                `ACR_ADDR_CH3_OFFSET_HIGH: begin
                    ch3_offset_high_next = reg_wdata;
                end
                default: begin
                    // Writes to unmapped addresses are dropped
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `ACR_ADDR_CH2_CONFIG: begin
                    rdata_next = ch2_config_reg;
                end
                `ACR_ADDR_CH2_OFFSET_HIGH: begin
                    rdata_next = ch2_offset_high_reg;
                end
                `ACR_ADDR_CH2_OFFSET_LOW: begin
                    rdata_next = ch2_offset_low_reg;
                end
                `ACR_ADDR_CH2_GAIN_HIGH: begin
                    rdata_next = ch2_gain_high_reg;
                end
                `ACR_ADDR_CH2_GAIN_LOW: begin
                    rdata_next = ch2_gain_low_reg;
                end
                `ACR_ADDR_CH3_CONFIG: begin
                    rdata_next = ch3_config_reg;
                end
                `ACR_ADDR_CH3_OFFSET_HIGH: begin
                    rdata_next = ch3_offset_high_reg;
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ch2_config_reg <= `ACR_RST_CH2_CONFIG;
            ch2_offset_high_reg <= `ACR_RST_CH2_OFFSET_HIGH;
            ch2_offset_low_reg <= `ACR_RST_CH2_OFFSET_LOW;
            ch2_gain_high_reg <= `ACR_RST_CH2_GAIN_HIGH;
            ch2_gain_low_reg <= `ACR_RST_CH2_GAIN_LOW;
            ch3_config_reg <= `ACR_RST_CH3_CONFIG;
            ch3_offset_high_reg <= `ACR_RST_CH3_OFFSET_HIGH;
            rdata_reg <= 16'h0000;
        end else begin
            ch2_config_reg <= ch2_config_next;
            ch2_offset_high_reg <= ch2_offset_high_next;
            ch2_offset_low_reg <= ch2_offset_low_next;
            ch2_gain_high_reg <= ch2_gain_high_next;
            ch2_gain_low_reg <= ch2_gain_low_next;
            ch3_config_reg <= ch3_config_next;
            ch3_offset_high_reg <= ch3_offset_high_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    assign sel_arr[0] = ch2_config_reg[`ACR_SEL_MSB:`ACR_SEL_LSB];
    assign sel_arr[1] = ch3_config_reg[`ACR_SEL_MSB:`ACR_SEL_LSB];

    // One router per channel
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_route
            acr_input_route u_route (
                .sel(sel_arr[g]),
                .pins_on(route_arr[g][0]),
                .shorted(route_arr[g][1]),
                .test_pos(route_arr[g][2]),
                .test_neg(route_arr[g][3])
            );
        end
    endgenerate

    assign ch2_input_select = sel_arr[0];
    assign ch3_input_select = sel_arr[1];
    assign {ch2_test_neg, ch2_test_pos, ch2_shorted, ch2_pins_on} =
        route_arr[0];
    assign {ch3_test_neg, ch3_test_pos, ch3_shorted, ch3_pins_on} =
        route_arr[1];

    acr_cal_join #(
        .IS_SIGNED(1'b1)
    ) u_offset_join (
        .upper_bits(ch2_offset_high_reg),
        .lower_reg(ch2_offset_low_reg),
        .value(ch2_offset),
        .top_flag(ch2_offset_neg)
    );

    acr_cal_join #(
        .IS_SIGNED(1'b0)
    ) u_gain_join (
        .upper_bits(ch2_gain_high_reg),
        .lower_reg(ch2_gain_low_reg),
        .value(ch2_gain),
        .top_flag(ch2_gain_ge_one)
    );

    assign ch3_offset_upper_bits = ch3_offset_high_reg;

    // Checks
    property p_ch2_route;
        @(posedge core_clk) disable iff (!nrst)
        (ch2_input_select == 2'b00) == ch2_pins_on &&
        (ch2_input_select == 2'b01) == ch2_shorted &&
        (ch2_input_select == 2'b10) == ch2_test_pos &&
        (ch2_input_select == 2'b11) == ch2_test_neg;
    endproperty
    a_ch2_route: assert property (p_ch2_route)
        else $error("channel 2 routing does not match select");

    property p_ch3_sel_write;
        @(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_addr == `ACR_ADDR_CH3_CONFIG) |=>
        ch3_input_select == $past(reg_wdata[1:0]) &&
        ch3_test_neg == ($past(reg_wdata[1:0]) == 2'b11) &&
        ch3_shorted == ($past(reg_wdata[1:0]) == 2'b01);
    endproperty
    a_ch3_sel_write: assert property (p_ch3_sel_write)
        else $error("channel 3 select write not routed");

    property p_ch2_off_high;
        @(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_addr == `ACR_ADDR_CH2_OFFSET_HIGH) |=>
        ch2_offset[23:8] == $past(reg_wdata);
    endproperty
    a_ch2_off_high: assert property (p_ch2_off_high)
        else $error("offset high bits not taken");

    property p_ch2_off_low;
        @(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_addr == `ACR_ADDR_CH2_OFFSET_LOW) ##1
        (reg_rd && reg_addr == `ACR_ADDR_CH2_OFFSET_LOW) |=>
        reg_rdata == {$past(reg_wdata[15:8], 2), 8'h00} &&
        ch2_offset[7:0] == $past(reg_wdata[15:8], 2);
    endproperty
    a_ch2_off_low: assert property (p_ch2_off_low)
        else $error("offset low byte wrong or reserved not zero");

    property p_offset_sign;
        @(posedge core_clk) disable iff (!nrst)
        ch2_offset_neg == ch2_offset_high_reg[15];
    endproperty
    a_offset_sign: assert property (p_offset_sign)
        else $error("offset sign flag mismatch");

    property p_gain_high;
        @(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_addr == `ACR_ADDR_CH2_GAIN_HIGH) |=>
        ch2_gain[23:8] == $past(reg_wdata) &&
        ch2_gain_ge_one == $past(reg_wdata[15]);
    endproperty
    a_gain_high: assert property (p_gain_high)
        else $error("gain high bits not taken");

    property p_gain_low;
        @(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_addr == `ACR_ADDR_CH2_GAIN_LOW) |=>
        ch2_gain[7:0] == $past(reg_wdata[15:8]) &&
        ch2_gain_low_reg[7:0] == 8'h00;
    endproperty
    a_gain_low: assert property (p_gain_low)
        else $error("gain low byte wrong");

    property p_reset_values;
        @(posedge core_clk)
        (nrst && !$past(nrst)) |->
        ch2_gain == 24'h800000 && ch2_offset == 24'h000000 &&
        ch3_config_reg == 16'h0000 && ch3_offset_upper_bits == 16'h0000;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("wrong value after reset");

    property p_ch3_off_high;
        @(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_addr == `ACR_ADDR_CH3_OFFSET_HIGH) ##1
        (reg_rd && reg_addr == `ACR_ADDR_CH3_OFFSET_HIGH) |=>
        reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_ch3_off_high: assert property (p_ch3_off_high)
        else $error("channel 3 offset high readback wrong");

    property p_cfg_reserved;
        @(posedge core_clk) disable iff (!nrst)
        (reg_rd && (reg_addr == `ACR_ADDR_CH2_CONFIG ||
        reg_addr == `ACR_ADDR_CH3_CONFIG)) |=>
        reg_rdata[5:3] == 3'h0;
    endproperty
    a_cfg_reserved: assert property (p_cfg_reserved)
        else $error("read-only reserved config bits not zero");

    property p_rdata_idle;
        @(posedge core_clk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");

    c_ch2_test_neg: cover property (@(posedge core_clk) disable iff (!nrst)
        ch2_test_neg);
    c_gain_write: cover property (@(posedge core_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_CH2_GAIN_HIGH);
    c_ch3_config_read: cover property (@(posedge core_clk) disable iff (!nrst)
        reg_rd && reg_addr == `ACR_ADDR_CH3_CONFIG ##1 reg_rdata != 16'h0000);
    c_offset_neg: cover property (@(posedge core_clk) disable iff (!nrst)
        ch2_offset_neg);

endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "acr_regs.svh"

module tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] ch2_input_select;
    logic ch2_pins_on, ch2_shorted, ch2_test_pos, ch2_test_neg;
    logic [1:0] ch3_input_select;
    logic ch3_pins_on, ch3_shorted, ch3_test_pos, ch3_test_neg;
    logic [23:0] ch2_offset;
    logic ch2_offset_neg;
    logic [23:0] ch2_gain;
    logic ch2_gain_ge_one;
    logic [15:0] ch3_offset_upper_bits;
    int fail_count = 0;
    int n_tests = 0;
    logic [1:0] s2;
    logic [1:0] s3;

    always #4 core_clk = ~core_clk;

    acr_calib_regs uut (
        .core_clk(core_clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .ch2_input_select(ch2_input_select),
        .ch2_pins_on(ch2_pins_on),
        .ch2_shorted(ch2_shorted),
        .ch2_test_pos(ch2_test_pos),
        .ch2_test_neg(ch2_test_neg),
        .ch3_input_select(ch3_input_select),
        .ch3_pins_on(ch3_pins_on),
        .ch3_shorted(ch3_shorted),
        .ch3_test_pos(ch3_test_pos),
        .ch3_test_neg(ch3_test_neg),
        .ch2_offset(ch2_offset),
        .ch2_offset_neg(ch2_offset_neg),
        .ch2_gain(ch2_gain),
        .ch2_gain_ge_one(ch2_gain_ge_one),
        .ch3_offset_upper_bits(ch3_offset_upper_bits)
    );

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: %s got %h expected %h",
                     $time, msg, got, exp);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data must stand for exactly one cycle, then return to zero
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp}, "read data");
        @(posedge core_clk);
        #1;
        chk({8'h00, reg_rdata}, 24'h000000, "read data after slot");
    endtask

    task automatic chk_route(input logic [1:0] c2, input logic [1:0] c3);
        chk({22'h000000, ch2_input_select}, {22'h000000, c2}, "ch2 sel");
        chk({20'h00000, ch2_pins_on, ch2_shorted, ch2_test_pos,
             ch2_test_neg}, {20'h00000, 4'h8 >> c2}, "ch2 route");
        chk({22'h000000, ch3_input_select}, {22'h000000, c3}, "ch3 sel");
        chk({20'h00000, ch3_pins_on, ch3_shorted, ch3_test_pos,
             ch3_test_neg}, {20'h00000, 4'h8 >> c3}, "ch3 route");
    endtask

    task automatic do_reset(input int cycles);
        nrst <= 1'b0;
        repeat (cycles) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
    endtask

    initial begin
        do_reset(6);
        rd(`ACR_ADDR_CH2_CONFIG, 16'h0000);
        rd(`ACR_ADDR_CH2_OFFSET_HIGH, 16'h0000);
        rd(`ACR_ADDR_CH2_OFFSET_LOW, 16'h0000);
        rd(`ACR_ADDR_CH2_GAIN_HIGH, 16'h8000);
        rd(`ACR_ADDR_CH2_GAIN_LOW, 16'h0000);
        rd(`ACR_ADDR_CH3_CONFIG, 16'h0000);
        rd(`ACR_ADDR_CH3_OFFSET_HIGH, 16'h0000);
        chk(ch2_gain, 24'h800000, "gain reset");
        chk({23'h0, ch2_gain_ge_one}, 24'h1, "unity flag");
        chk_route(2'b00, 2'b00);
        $display("test reset values done");

        for (int i = 0; i < 4; i++) begin
            s2 = i[1:0];
            s3 = ~s2;
            wr(`ACR_ADDR_CH2_CONFIG, {14'h0000, s2});
            wr(`ACR_ADDR_CH3_CONFIG, {14'h0000, s3});
            chk_route(s2, s3);
        end
        wr(`ACR_ADDR_CH2_CONFIG, 16'hffff);
        rd(`ACR_ADDR_CH2_CONFIG, 16'hffc7);
        chk_route(2'b11, 2'b00);
        wr(`ACR_ADDR_CH3_CONFIG, 16'h007d);
        rd(`ACR_ADDR_CH3_CONFIG, 16'h0045);
        chk_route(2'b11, 2'b01);
        $display("test input select done");

        wr(`ACR_ADDR_CH2_OFFSET_HIGH, 16'h8000);
        wr(`ACR_ADDR_CH2_OFFSET_LOW, 16'h12ab);
        rd(`ACR_ADDR_CH2_OFFSET_LOW, 16'h1200);
        chk(ch2_offset, 24'h800012, "offset join");
        chk({23'h0, ch2_offset_neg}, 24'h1, "offset sign");
        wr(`ACR_ADDR_CH2_OFFSET_HIGH, 16'h7fff);
        wr(`ACR_ADDR_CH2_OFFSET_LOW, 16'hff00);
        rd(`ACR_ADDR_CH2_OFFSET_HIGH, 16'h7fff);
        chk(ch2_offset, 24'h7fffff, "offset max");
        chk({23'h0, ch2_offset_neg}, 24'h0, "offset sign");
        $display("test offset done");

        wr(`ACR_ADDR_CH2_GAIN_HIGH, 16'h4000);
        chk(ch2_gain, 24'h400000, "gain high");
        chk({23'h0, ch2_gain_ge_one}, 24'h0, "gain below one");
        wr(`ACR_ADDR_CH2_GAIN_LOW, 16'hffff);
        rd(`ACR_ADDR_CH2_GAIN_LOW, 16'hff00);
        chk(ch2_gain, 24'h4000ff, "gain join");
        wr(`ACR_ADDR_CH2_GAIN_HIGH, 16'hffff);
        rd(`ACR_ADDR_CH2_GAIN_HIGH, 16'hffff);
        chk(ch2_gain, 24'hffffff, "gain top");
        chk({23'h0, ch2_gain_ge_one}, 24'h1, "gain above one");
        $display("test gain done");

        wr(`ACR_ADDR_CH3_OFFSET_HIGH, 16'ha5c3);
        rd(`ACR_ADDR_CH3_OFFSET_HIGH, 16'ha5c3);
        chk({8'h00, ch3_offset_upper_bits}, 24'h00a5c3, "ch3 off");
        $display("test ch3 offset done");

        wr(8'h1a, 16'h1234);
        rd(8'h1a, 16'h0000);
        rd(8'h12, 16'h0000);
        rd(8'h94, 16'h0000);
        chk(ch2_offset, 24'h7fffff, "offset kept");
        chk({8'h00, ch3_offset_upper_bits}, 24'h00a5c3, "ch3 kept");
        $display("test unmapped done");

        do_reset(2);
        chk(ch2_gain, 24'h800000, "gain second reset");
        chk(ch2_offset, 24'h000000, "offset second reset");
        chk({8'h00, ch3_offset_upper_bits}, 24'h0, "ch3 reset");
        chk_route(2'b00, 2'b00);
        rd(`ACR_ADDR_CH2_GAIN_HIGH, 16'h8000);
        $display("test second reset done");
        stop_test();
    end

    initial begin
        #(8 * 3000);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
